// [shared/cpf_pkg.sv]
package cpf_pkg;

    // timebase and delays (core clock 25 MHz)
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned OVC_DELAY_MS    = 1024;
    localparam int unsigned ODC_DELAY_MS    = 16;
    localparam int unsigned DOC_DELAY_MS    = 32;
    localparam int unsigned SHORT_DELAY_MS  = 1;
    localparam int unsigned COC_DELAY_MS    = 8;
    localparam int unsigned TDET_DELAY_MS   = 128;
    localparam int unsigned TREL_DELAY_MS   = 128;
    localparam int unsigned TSENSE_MS       = 10;
    localparam int unsigned TSAMPLE_MS      = 1000;
    localparam int unsigned BOOST_GUARD_MS  = 32;
    localparam int unsigned TEST_DIV        = 16;
    localparam int          CNT_W           = 16;

    typedef enum logic [1:0] {
        CPF_NORMAL,
        CPF_STANDBY,
        CPF_ZERO_V_INHIBIT
    } cpf_mode_t;

    // comparator results, all synchronous levels
    typedef struct packed {
        logic over_charge;
        logic over_discharge;
        logic below_inhibit_max;
        logic sense_overcurrent;
        logic sense_short;
        logic charge_overcurrent;
        logic term_above_release;
        logic term_above_charger;
        logic term_above_standby;
        logic term_above_test;
        logic charger_present;
        logic hot_charge;
        logic cool_charge;
        logic hot_discharge;
        logic cool_discharge;
        logic gates_boosted;
        logic control_pin_low;
    } cpf_sense_t;

    typedef struct packed {
        logic charge_gate;
        logic discharge_gate;
        logic charge_gate_boosted;
        logic pack_pullup_en;
        logic charge_pump_en;
        logic thermistor_bias_en;
        logic test_mode;
        logic standby;
    } cpf_drive_t;

endpackage

// [logic/cpf_delay_filter.sv]
`timescale 1ns/1ps
module cpf_delay_filter
    import cpf_pkg::*;
#(
    parameter int unsigned DELAY_TICKS = 1
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    // timebase and condition
    input  wire logic tick_i,
    input  wire logic cond_i,
    // qualified output
    output logic      done_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } cpf_flt_state_t;

    cpf_flt_state_t state_reg;
    cpf_flt_state_t state_next;

    // refuse delays the counter cannot reach
    if (DELAY_TICKS < 1 || DELAY_TICKS >= (1 << CNT_W)) begin : g_bad_delay
        $error("delay out of range");
    end

    // counter restarts whenever the qualifying condition drops
    always_comb begin
        state_next = state_reg;
        if (!cond_i) begin
            state_next.cnt  = '0;
            state_next.done = 1'b0;
        end else if (tick_i && !state_reg.done) begin
            if (state_reg.cnt == CNT_W'(DELAY_TICKS - 1))
                state_next.done = 1'b1;
            else
                state_next.cnt = state_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign done_o = state_reg.done;
endmodule

// [logic/cpf_protect.sv]
`timescale 1ns/1ps
module cpf_protect
    import cpf_pkg::*;
#(
    parameter int unsigned OVC_MS    = OVC_DELAY_MS,
    parameter int unsigned TSAMPLE   = TSAMPLE_MS,
    parameter int unsigned TICK_CLKS = TICK_CYCLES
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         reset_n_i,
    // comparator inputs
    input  wire cpf_sense_t   sense_i,
    // gate and analog controls
    output cpf_pkg::cpf_drive_t drive_o
);
    import cpf_pkg::*;

    localparam int unsigned TSENSE_T = TSENSE_MS;
    localparam int DIV_W = 20;

    if (TSAMPLE <= TSENSE_T || TSAMPLE >= (1 << CNT_W)) begin : g_bad_sample
        $error("sampling period must exceed sense window");
    end
    if (TICK_CLKS < 1 || TICK_CLKS >= (1 << DIV_W)) begin : g_bad_tick
        $error("tick divider out of range");
    end

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic             tick;
        logic [CNT_W-1:0] samp;
        logic [CNT_W-1:0] guard;
        cpf_mode_t        mode;
        logic             ovc_lat;
        logic             odc_lat;
        logic             doc_lat;
        logic             coc_lat;
        logic             thc_lat;
        logic             thd_lat;
        logic             test;
        cpf_drive_t       drive;
    } cpf_state_t;

    cpf_state_t state_reg;
    cpf_state_t state_next;

    logic tick;
    logic fast_tick;
    logic therm_window;
    logic ovc_done, odc_done, doc_done, sht_done, coc_done;
    logic thc_set, thd_set, thc_clr, thd_clr;

    // test mode shortens delays by running the filters faster
    assign tick = state_reg.tick;
    assign fast_tick = state_reg.tick | (state_reg.test & (state_reg.div[3:0] == 4'h0));
    assign therm_window = state_reg.test || (state_reg.samp < CNT_W'(TSENSE_T));

    cpf_delay_filter #(.DELAY_TICKS(OVC_MS)) u_ovc (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick),
        .cond_i     (sense_i.over_charge),
        .done_o     (ovc_done)
    );
    // control pin low forces the same path as low cell voltage
    cpf_delay_filter #(.DELAY_TICKS(ODC_DELAY_MS)) u_odc (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick),
        .cond_i     (sense_i.over_discharge | sense_i.control_pin_low),
        .done_o     (odc_done)
    );
    cpf_delay_filter #(.DELAY_TICKS(DOC_DELAY_MS)) u_doc (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick),
        .cond_i     (sense_i.sense_overcurrent & !state_reg.test),
        .done_o     (doc_done)
    );
    cpf_delay_filter #(.DELAY_TICKS(SHORT_DELAY_MS)) u_sht (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick),
        .cond_i     (sense_i.sense_short & !state_reg.test),
        .done_o     (sht_done)
    );
    cpf_delay_filter #(.DELAY_TICKS(COC_DELAY_MS)) u_coc (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick),
        .cond_i     (sense_i.charge_overcurrent & !state_reg.test),
        .done_o     (coc_done)
    );
    // thermal inputs count in the sense window or test mode, also in standby with the bias off
    cpf_delay_filter #(.DELAY_TICKS(TDET_DELAY_MS)) u_thc (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick & therm_window),
        .cond_i     (sense_i.hot_charge),
        .done_o     (thc_set)
    );
    cpf_delay_filter #(.DELAY_TICKS(TDET_DELAY_MS)) u_thd (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick & therm_window),
        .cond_i     (sense_i.hot_discharge),
        .done_o     (thd_set)
    );
    cpf_delay_filter #(.DELAY_TICKS(TREL_DELAY_MS)) u_tcr (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick & therm_window),
        .cond_i     (sense_i.cool_charge & state_reg.thc_lat),
        .done_o     (thc_clr)
    );
    cpf_delay_filter #(.DELAY_TICKS(TREL_DELAY_MS)) u_tdr (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .tick_i     (fast_tick & therm_window),
        .cond_i     (sense_i.cool_discharge & state_reg.thd_lat),
        .done_o     (thd_clr)
    );

    always_comb begin
        state_next = state_reg;

        // millisecond timebase
        state_next.tick = 1'b0;
        if (state_reg.div == DIV_W'(TICK_CLKS - 1)) begin
            state_next.div  = '0;
            state_next.tick = 1'b1;
        end else begin
            state_next.div = state_reg.div + 20'h00001;
        end

        // thermistor sampling period counter
        if (tick) begin
            if (state_reg.samp == CNT_W'(TSAMPLE - 1))
                state_next.samp = '0;
            else
                state_next.samp = state_reg.samp + 16'h0001;
        end

        // overcharge: charger present needs removal and loaded terminal
        if (ovc_done)
            state_next.ovc_lat = 1'b1;
        else if (state_reg.ovc_lat && !sense_i.over_charge) begin
            if (!sense_i.charger_present)
                state_next.ovc_lat = 1'b0;
            if (sense_i.charger_present || sense_i.term_above_release)
                state_next.ovc_lat = state_reg.ovc_lat;
        end

        // overdischarge latch and release
        if (odc_done)
            state_next.odc_lat = 1'b1;
        else if (state_reg.odc_lat && !sense_i.over_discharge && !sense_i.control_pin_low
                 && (sense_i.term_above_charger || sense_i.charger_present))
            state_next.odc_lat = 1'b0;

        // discharge overcurrent and short share one latch
        if (doc_done || sht_done)
            state_next.doc_lat = 1'b1;
        else if (state_reg.doc_lat && sense_i.term_above_release)
            state_next.doc_lat = 1'b0;

        if (coc_done)
            state_next.coc_lat = 1'b1;
        else if (!sense_i.charger_present)
            state_next.coc_lat = 1'b0;

        // thermal latches: set wins over release
        if (thc_set)
            state_next.thc_lat = 1'b1;
        else if (thc_clr)
            state_next.thc_lat = 1'b0;
        if (thd_set)
            state_next.thd_lat = 1'b1;
        else if (thd_clr)
            state_next.thd_lat = 1'b0;

        // boost guard: entry refused until 32 ms after both gates boosted
        if (!sense_i.gates_boosted)
            state_next.guard = '0;
        else if (tick && state_reg.guard != CNT_W'(BOOST_GUARD_MS))
            state_next.guard = state_reg.guard + 16'h0001;
        if (sense_i.term_above_test && !state_reg.test
            && state_reg.guard == CNT_W'(BOOST_GUARD_MS) && sense_i.gates_boosted)
            state_next.test = 1'b1;
        else if (!sense_i.term_above_test)
            state_next.test = 1'b0;

        // standby and zero-volt inhibition
        case (state_reg.mode)
            CPF_NORMAL: begin
                // standby when the terminal falls under the detect level while overdischarge is latched
                if (state_reg.odc_lat && !sense_i.term_above_standby)
                    state_next.mode = CPF_STANDBY;
            end
            CPF_STANDBY: begin
                if (sense_i.term_above_charger && sense_i.below_inhibit_max)
                    state_next.mode = CPF_ZERO_V_INHIBIT;
                else if (sense_i.term_above_charger && !sense_i.control_pin_low)
                    state_next.mode = CPF_NORMAL;
            end
            CPF_ZERO_V_INHIBIT: begin
                if (!sense_i.below_inhibit_max)
                    state_next.mode = CPF_NORMAL;
            end
            default: state_next.mode = CPF_NORMAL;
        endcase
        if (state_next.mode == CPF_NORMAL && state_reg.mode != CPF_NORMAL
            && !sense_i.over_discharge && !sense_i.control_pin_low)
            state_next.odc_lat = 1'b0;

        // gate outputs: each gate high only when the blocks on that gate are released
        state_next.drive.charge_gate = !(state_next.ovc_lat || state_next.coc_lat
            || state_next.thc_lat || state_next.mode == CPF_ZERO_V_INHIBIT);
        // control pin acts only through the filtered latch, so it waits out the delay
        state_next.drive.discharge_gate = !(state_next.odc_lat || state_next.doc_lat
            || state_next.thd_lat);
        state_next.drive.standby = (state_next.mode == CPF_STANDBY);
        // pump off in standby and test, so a high gate sits at cell level
        state_next.drive.charge_pump_en = !state_next.drive.standby && !state_next.test;
        state_next.drive.charge_gate_boosted = state_next.drive.charge_gate
            && state_next.drive.charge_pump_en;
        state_next.drive.pack_pullup_en = state_next.doc_lat;
        state_next.drive.thermistor_bias_en = !state_next.drive.standby
            && (state_next.test || state_next.samp < CNT_W'(TSENSE_T));
        state_next.drive.test_mode = state_next.test;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign drive_o = state_reg.drive;
endmodule

// [tb/cpf_protect_checker.sv]
`timescale 1ns/1ps
module cpf_protect_checker
    import cpf_pkg::*;
#(
    parameter int unsigned OVC_MS    = OVC_DELAY_MS,
    parameter int unsigned TSAMPLE   = TSAMPLE_MS,
    parameter int unsigned TICK_CLKS = TICK_CYCLES
) (
    // clock and reset
    input wire logic                core_clk_i,
    input wire logic                reset_n_i,
    // watched ports
    input wire cpf_pkg::cpf_sense_t sense_i,
    input wire cpf_pkg::cpf_drive_t drive_o
);
    int unsigned oc_cnt;
    int unsigned od_cnt;
    int unsigned cp_cnt;
    int unsigned sh_cnt;
    int unsigned bias_cnt;
    int unsigned bst_cnt;

    // run lengths of held conditions; no saturation, runs stay short
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oc_cnt   <= 0;
            od_cnt   <= 0;
            cp_cnt   <= 0;
            sh_cnt   <= 0;
            bias_cnt <= 0;
            bst_cnt  <= 0;
        end else begin
            oc_cnt   <= sense_i.over_charge ? oc_cnt + 1 : 0;
            od_cnt   <= sense_i.over_discharge ? od_cnt + 1 : 0;
            cp_cnt   <= sense_i.control_pin_low ? cp_cnt + 1 : 0;
            sh_cnt   <= (sense_i.sense_short && !drive_o.test_mode) ? sh_cnt + 1 : 0;
            bias_cnt <= (drive_o.thermistor_bias_en && !drive_o.test_mode) ? bias_cnt + 1 : 0;
            bst_cnt  <= sense_i.gates_boosted ? bst_cnt + 1 : 0;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_ovc;
        oc_cnt >= (OVC_MS + 1) * TICK_CLKS + 4 |-> !drive_o.charge_gate;
    endproperty
    a_ovc: assert property (p_ovc)
        else $error("charge gate high under long overcharge");
    property p_odc;
        od_cnt >= (ODC_DELAY_MS + 1) * TICK_CLKS + 4 |-> !drive_o.discharge_gate;
    endproperty
    a_odc: assert property (p_odc)
        else $error("discharge gate high under long overdischarge");
    property p_ctl;
        cp_cnt >= (ODC_DELAY_MS + 1) * TICK_CLKS + 4 |-> !drive_o.discharge_gate;
    endproperty
    a_ctl: assert property (p_ctl)
        else $error("discharge gate high with control pin low");
    property p_short;
        sh_cnt >= (SHORT_DELAY_MS + 1) * TICK_CLKS + 4 |-> !drive_o.discharge_gate;
    endproperty
    a_short: assert property (p_short)
        else $error("discharge gate high under short");
    property p_bias;
        bias_cnt <= TSENSE_MS * TICK_CLKS + 3;
    endproperty
    a_bias: assert property (p_bias)
        else $error("thermistor bias window too long");
    property p_guard;
        $rose(drive_o.test_mode) |-> $past(bst_cnt) >= (BOOST_GUARD_MS - 1) * TICK_CLKS;
    endproperty
    a_guard: assert property (p_guard)
        else $error("test mode entered before boost guard");
    property p_standby;
        drive_o.standby |-> !drive_o.charge_pump_en && !drive_o.charge_gate_boosted;
    endproperty
    a_standby: assert property (p_standby)
        else $error("pump or boost active in standby");
    property p_test;
        drive_o.test_mode |-> !drive_o.charge_pump_en && drive_o.thermistor_bias_en;
    endproperty
    a_test: assert property (p_test)
        else $error("test mode outputs wrong");
    property p_pull;
        drive_o.pack_pullup_en |-> !drive_o.discharge_gate;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull-up on with discharge gate high");
    property p_prel;
        drive_o.pack_pullup_en && sense_i.term_above_release && !sense_i.sense_overcurrent
            && !sense_i.sense_short |-> ##[1:2] !drive_o.pack_pullup_en;
    endproperty
    a_prel: assert property (p_prel)
        else $error("pull-up not released");
endmodule

// [tb/cpf_pack_model.sv]
`timescale 1ns/1ps
module cpf_pack_model
    import cpf_pkg::*;
(
    // bench stimulus
    input  wire cpf_pkg::cpf_sense_t req_i,
    input  wire logic                load_on_i,
    // device outputs
    input  wire cpf_pkg::cpf_drive_t drive_i,
    // comparator view of the pack
    output cpf_pkg::cpf_sense_t      sense_o
);
    always_comb begin
        sense_o = req_i;
        // a connected load holds the terminal down against the pull-up
        if (drive_i.pack_pullup_en && !load_on_i) begin
            sense_o.term_above_release = 1'b1;
        end
        sense_o.gates_boosted = drive_i.charge_pump_en && drive_i.charge_gate
                                && drive_i.discharge_gate;
    end
endmodule

// [tb/test_cpf_protect.sv]
`timescale 1ns/1ps
module test_cpf_protect;
    import cpf_pkg::*;
    localparam int unsigned OVC = 4;
    localparam int unsigned TS  = 20;
    localparam int unsigned TK  = 10;
    // bit positions inside cpf_drive_t
    localparam int CG = 7;
    localparam int DG = 6;
    localparam int TM = 1;
    localparam int SB = 0;
    logic       core_clk_i;
    logic       reset_n_i;
    logic       load_on;
    cpf_sense_t req;
    cpf_sense_t sense;
    cpf_drive_t drive;
    int         num_errors;
    int         total_checks;
    int         n;

    cpf_protect #(.OVC_MS(OVC), .TSAMPLE(TS), .TICK_CLKS(TK)) i_cpf_protect (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sense_i(sense), .drive_o(drive));
    cpf_pack_model i_cpf_pack_model (
        .req_i(req), .load_on_i(load_on), .drive_i(drive), .sense_o(sense));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    // bounded wait for a drive bit; a miss ends the run
    task automatic wt(input int b, input logic v, input int lim, output int k);
        k = 0;
        while (drive[b] !== v && k < lim) begin
            cyc(1);
            k++;
        end
        chk(drive[b] === v, "drive bit did not settle");
        if (drive[b] !== v) summarize();
    endtask
    task automatic hold(input int b, input logic v, input int k);
        repeat (k) begin
            cyc(1);
            chk(drive[b] === v, "drive bit moved");
        end
    endtask
    task automatic rst;
        req = '0;
        load_on = 1'b1;
        reset_n_i = 1'b0;
        cyc(8);
        chk(drive === '0, "outputs not cleared in reset");
        reset_n_i = 1'b1;
        cyc(3);
        chk(drive[CG] === 1'b1 && drive[DG] === 1'b1, "gates not up");
    endtask
    task automatic pulse_ovc;
        req.over_charge = 1'b1;
        wt(CG, 1'b0, OVC * TK + 5, n);
    endtask
    task automatic t_ovc;
        rst();
        req.over_charge = 1'b1;
        cyc((OVC - 2) * TK);
        req.over_charge = 1'b0;
        hold(CG, 1'b1, 3 * TK);
        pulse_ovc();
        chk(n >= (OVC - 1) * TK, "overcharge caught early");
        req.charger_present = 1'b1;
        req.over_charge = 1'b0;
        hold(CG, 1'b0, 2 * TK);
        req.term_above_release = 1'b1;
        req.charger_present = 1'b0;
        hold(CG, 1'b0, 2 * TK);
        req.term_above_release = 1'b0;
        wt(CG, 1'b1, 2, n);
        pulse_ovc();
        req.over_charge = 1'b0;
        wt(CG, 1'b1, 2, n);
    endtask
    task automatic t_odc;
        rst();
        req.over_discharge = 1'b1;
        cyc((ODC_DELAY_MS - 2) * TK);
        req.over_discharge = 1'b0;
        hold(DG, 1'b1, 3 * TK);
        req.over_discharge = 1'b1;
        wt(DG, 1'b0, ODC_DELAY_MS * TK + 5, n);
        wt(SB, 1'b1, 5, n);
        hold(CG, 1'b1, 2);
        chk(drive.charge_pump_en === 1'b0 && drive.charge_gate_boosted === 1'b0,
            "pump still on in standby");
        req.below_inhibit_max = 1'b1;
        req.term_above_charger = 1'b1;
        req.charger_present = 1'b1;
        wt(CG, 1'b0, 5, n);
        rst();
        req.over_discharge = 1'b1;
        wt(DG, 1'b0, ODC_DELAY_MS * TK + 5, n);
        req.over_discharge = 1'b0;
        req.term_above_charger = 1'b1;
        req.charger_present = 1'b1;
        wt(DG, 1'b1, 3, n);
    endtask
    task automatic t_ctl;
        rst();
        req.control_pin_low = 1'b1;
        hold(DG, 1'b1, (ODC_DELAY_MS - 2) * TK);
        wt(DG, 1'b0, 4 * TK, n);
        req.term_above_charger = 1'b1;
        req.charger_present = 1'b1;
        hold(DG, 1'b0, 2 * TK);
    endtask
    task automatic t_doc;
        rst();
        req.sense_overcurrent = 1'b1;
        cyc((DOC_DELAY_MS - 2) * TK);
        req.sense_overcurrent = 1'b0;
        hold(DG, 1'b1, 3 * TK);
        req.sense_short = 1'b1;
        wt(DG, 1'b0, 2 * TK + 5, n);
        chk(drive.pack_pullup_en === 1'b1, "no pull-up while latched");
        req.sense_short = 1'b0;
        load_on = 1'b0;
        wt(DG, 1'b1, 4, n);
        chk(drive.pack_pullup_en === 1'b0, "pull-up left on");
        load_on = 1'b1;
        req.sense_overcurrent = 1'b1;
        wt(DG, 1'b0, DOC_DELAY_MS * TK + 5, n);
        chk(n >= (DOC_DELAY_MS - 1) * TK, "overcurrent caught early");
    endtask
    task automatic t_coc;
        rst();
        req.charger_present = 1'b1;
        req.charge_overcurrent = 1'b1;
        cyc((COC_DELAY_MS - 2) * TK);
        req.charge_overcurrent = 1'b0;
        hold(CG, 1'b1, 3 * TK);
        req.charge_overcurrent = 1'b1;
        wt(CG, 1'b0, COC_DELAY_MS * TK + 5, n);
        req.charge_overcurrent = 1'b0;
        hold(CG, 1'b0, 2 * TK);
        req.charger_present = 1'b0;
        wt(CG, 1'b1, 3, n);
    endtask
    task automatic t_hot;
        rst();
        req.hot_charge = 1'b1;
        req.hot_discharge = 1'b1;
        wt(CG, 1'b0, 3 * TDET_DELAY_MS * TK, n);
        chk(n >= (TDET_DELAY_MS - 1) * TK, "thermal caught early");
        wt(DG, 1'b0, 2 * TK, n);
        req.hot_charge = 1'b0;
        req.hot_discharge = 1'b0;
        req.cool_charge = 1'b1;
        req.cool_discharge = 1'b1;
        wt(CG, 1'b1, 3 * TREL_DELAY_MS * TK, n);
        wt(DG, 1'b1, 2 * TK, n);
    endtask
    task automatic t_test;
        rst();
        req.term_above_test = 1'b1;
        hold(TM, 1'b0, (BOOST_GUARD_MS - 2) * TK);
        wt(TM, 1'b1, 4 * TK, n);
        req.sense_short = 1'b1;
        hold(DG, 1'b1, 4 * TK);
    endtask

    initial begin
        num_errors = 0;
        total_checks = 0;
        t_ovc();
        t_odc();
        t_ctl();
        t_doc();
        t_coc();
        t_hot();
        t_test();
        summarize();
    end
endmodule

bind cpf_protect cpf_protect_checker #(
    .OVC_MS(OVC_MS), .TSAMPLE(TSAMPLE), .TICK_CLKS(TICK_CLKS)
) i_cpf_protect_checker (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sense_i(sense_i), .drive_o(drive_o));
